// file: common/chip_cfg_pkg.sv
// Shared types and constants for the chip mode and security configuration.
// Assumes one 20 MHz system clock and an active-low asynchronous reset.
package chip_cfg_pkg;

   // Operating modes, coded as {high, mid, low} strap levels
   typedef enum logic [2:0] {
      MODE_SPECIAL_SINGLE = 3'h0,
      MODE_EMUL_NARROW    = 3'h1,
      MODE_SPECIAL_TEST   = 3'h2,
      MODE_EMUL_WIDE      = 3'h3,
      MODE_NORMAL_SINGLE  = 3'h4,
      MODE_NORMAL_NARROW  = 3'h5,
      MODE_PERIPHERAL     = 3'h6,
      MODE_NORMAL_WIDE    = 3'h7
   } op_mode_t;

   // Strap levels as they come off the pins
   typedef struct packed {
      logic mode_high;
      logic mode_mid;
      logic mode_low;
      logic flash_vis;
      logic osc_sel;
   } strap_t;

   localparam int     STRAP_W        = 5;
   localparam strap_t STRAP_RESET    = 5'h00;
   // Edges after release before the filtered straps are trusted
   localparam logic [2:0] CAPTURE_CYCLES = 3'h4;

   typedef enum logic [1:0] {
      CAP_WAIT = 2'h0,
      CAP_DONE = 2'h1
   } cap_state_t;

   typedef enum logic [1:0] {
      PWR_RUN   = 2'h0,
      PWR_WAIT  = 2'h1,
      PWR_STOP  = 2'h2,
      PWR_PSTOP = 2'h3
   } pwr_state_t;

   // Clock gates handed to the clock generator
   typedef struct packed {
      logic osc_run;
      logic core_clk;
      logic periph_clk;
      logic tick_clk;
      logic wdog_clk;
      logic cpu_hold;
   } clk_gate_t;

   localparam clk_gate_t GATE_RUN   = 6'h3E;
   localparam clk_gate_t GATE_WAIT  = 6'h2F;
   localparam clk_gate_t GATE_STOP  = 6'h01;
   localparam clk_gate_t GATE_PSTOP = 6'h21;

   // Modes that drive the external bus
   function automatic logic is_expanded(input op_mode_t m);
      is_expanded = (m != MODE_SPECIAL_SINGLE)
                  && (m != MODE_NORMAL_SINGLE);
   endfunction : is_expanded

endpackage : chip_cfg_pkg

// file: rtl/strap_sync.sv
// Three-stage synchroniser with agreement filter for the strap pins.
// Assumes the straps are board levels, static around reset release.
`timescale 1ns/1ps
module strap_sync (
   input  wire logic                 clk_i,
   input  wire logic                 arst_n_i,
   input  wire chip_cfg_pkg::strap_t pins_i,
   output      chip_cfg_pkg::strap_t straps_o
);

   typedef struct packed {
      chip_cfg_pkg::strap_t s1;
      chip_cfg_pkg::strap_t s2;
      chip_cfg_pkg::strap_t s3;
      chip_cfg_pkg::strap_t q;
   } sync_state_t;

   sync_state_t state_reg;
   sync_state_t state_next;

   // Stage one feeds only stage two; a change counts once two and three agree
   always_comb
   begin
      state_next    = state_reg;
      state_next.s1 = pins_i;
      state_next.s2 = state_reg.s1;
      state_next.s3 = state_reg.s2;
      if (state_reg.s2 == state_reg.s3)
      begin
         state_next.q = state_reg.s3;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state_reg <= {4{chip_cfg_pkg::STRAP_RESET}};
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign straps_o = state_reg.q;

endmodule : strap_sync

// file: rtl/power_modes.sv
// Low-power state machine: run, wait, full stop and pseudo-stop.
// Assumes stop and wait requests are one-cycle pulses from the core.
`timescale 1ns/1ps
module power_modes (
   input  wire logic                     clk_i,
   input  wire logic                     arst_n_i,
   input  wire logic                     stop_exec_i,
   input  wire logic                     wait_exec_i,
   input  wire logic                     pseudo_stop_en_i,
   input  wire logic                     tick_keep_i,
   input  wire logic                     wdog_keep_i,
   input  wire logic                     ext_irq_i,
   input  wire logic                     tick_irq_i,
   input  wire logic                     any_irq_i,
   output      chip_cfg_pkg::pwr_state_t pwr_state_o,
   output      chip_cfg_pkg::clk_gate_t  gate_o
);

   typedef struct packed {
      chip_cfg_pkg::pwr_state_t st;
      chip_cfg_pkg::clk_gate_t  g;
   } pwr_reg_t;

   pwr_reg_t state_reg;
   pwr_reg_t state_next;

   // Wake from stop is modelled synchronously; real silicon wakes the
   // oscillator asynchronously before this logic sees a clock again
   always_comb
   begin
      state_next = state_reg;
      case (state_reg.st)
         chip_cfg_pkg::PWR_RUN:
         begin
            if (stop_exec_i)
            begin
               state_next.st = pseudo_stop_en_i ? chip_cfg_pkg::PWR_PSTOP
                                                : chip_cfg_pkg::PWR_STOP;
            end
            else if (wait_exec_i)
            begin
               state_next.st = chip_cfg_pkg::PWR_WAIT;
            end
         end
         chip_cfg_pkg::PWR_WAIT:
         begin
            if (any_irq_i)
            begin
               state_next.st = chip_cfg_pkg::PWR_RUN;
            end
         end
         chip_cfg_pkg::PWR_STOP:
         begin
            if (ext_irq_i)
            begin
               state_next.st = chip_cfg_pkg::PWR_RUN;
            end
         end
         chip_cfg_pkg::PWR_PSTOP:
         begin
            if (ext_irq_i || tick_irq_i)
            begin
               state_next.st = chip_cfg_pkg::PWR_RUN;
            end
         end
         default:
         begin
            state_next.st = chip_cfg_pkg::PWR_RUN;
         end
      endcase
      // Gates follow the next state so they change with it
      case (state_next.st)
         chip_cfg_pkg::PWR_WAIT:  state_next.g = chip_cfg_pkg::GATE_WAIT;
         chip_cfg_pkg::PWR_STOP:  state_next.g = chip_cfg_pkg::GATE_STOP;
         chip_cfg_pkg::PWR_PSTOP:
         begin
            state_next.g          = chip_cfg_pkg::GATE_PSTOP;
            state_next.g.tick_clk = tick_keep_i;
            state_next.g.wdog_clk = wdog_keep_i;
         end
         default:                 state_next.g = chip_cfg_pkg::GATE_RUN;
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state_reg.st <= chip_cfg_pkg::PWR_RUN;
         state_reg.g  <= chip_cfg_pkg::GATE_RUN;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign pwr_state_o = state_reg.st;
   assign gate_o      = state_reg.g;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   chk_stop_static: assert property (
      state_reg.st == chip_cfg_pkg::PWR_STOP |-> gate_o == 6'h01)
      else $error("clocks running in full stop");
   chk_pstop_osc: assert property (
      state_reg.st == chip_cfg_pkg::PWR_PSTOP
      |-> gate_o.osc_run && !gate_o.periph_clk && !gate_o.core_clk)
      else $error("pseudo-stop gating wrong");
   chk_wait_periph: assert property (
      $rose(state_reg.st == chip_cfg_pkg::PWR_WAIT)
      |-> gate_o.periph_clk && gate_o.cpu_hold && !gate_o.core_clk)
      else $error("wait gating wrong");

endmodule : power_modes

// file: rtl/chip_mode_config.sv
// Chip mode, flash visibility, oscillator and security configuration.
// Assumes strap pins are asynchronous board levels and all other inputs
// come from logic on clk_i; security input mirrors the flash NV bits.
// Function
// - Mode straps are captured at reset release and report active mode.
// - Flash-visibility strap is captured at release through mode mapping.
// - Flash visible bit one maps internal flash; zero removes it.
// - All straps low: special single chip, debug active, flash visible.
// - Other modes allow debug, inactive until activation command.
// - Strap 001 is emulation narrow; flash visible is inverse strap.
// - Strap 010 is special test wide; flash never visible.
// - Strap 011 is emulation wide; flash visible is inverse strap.
// - Strap 100 is normal single chip; flash always visible.
// - Strap 101 is normal narrow; flash visible equals strap.
// - Strap 111 is normal wide; flash visible equals strap.
// - Oscillator strap one picks Colpitts, zero Pierce or external clock.
// - Software mode writes allow only a restricted set of changes.
// - Secured normal single chip works normally but refuses debug.
// - Secured expanded mode hides internal flash and refuses debug.
// - Security comes from nonvolatile bits, held across every reset.
// - Unsecuring needs flash erase or the backdoor key path.
// - Reset before reprogramming security bits returns secured state.
// - Full stop halts all clocks; exits on reset or external interrupt.
// - Pseudo-stop keeps oscillator, optional tick and watchdog.
// - Wait halts the core with static buses; peripherals stay clocked.
`timescale 1ns/1ps
module chip_mode_config (
   input  wire logic                     clk_i,
   input  wire logic                     arst_n_i,
   input  wire logic                     mode_strap_high_i,
   input  wire logic                     mode_strap_mid_i,
   input  wire logic                     mode_strap_low_i,
   input  wire logic                     flash_visible_strap_i,
   input  wire logic                     oscillator_select_strap_i,
   input  wire logic                     secure_nv_i,
   input  wire logic                     flash_blank_i,
   input  wire logic                     backdoor_key_ok_i,
   input  wire logic                     mode_wr_i,
   input  wire chip_cfg_pkg::op_mode_t   mode_wr_data_i,
   input  wire logic                     debug_activate_i,
   input  wire logic                     debug_req_i,
   input  wire logic                     stop_exec_i,
   input  wire logic                     wait_exec_i,
   input  wire logic                     pseudo_stop_en_i,
   input  wire logic                     tick_keep_i,
   input  wire logic                     wdog_keep_i,
   input  wire logic                     ext_irq_i,
   input  wire logic                     tick_irq_i,
   input  wire logic                     any_irq_i,
   output      logic                     config_valid_o,
   output      chip_cfg_pkg::op_mode_t   op_mode_o,
   output      logic                     flash_visible_bit_o,
   output      logic                     flash_map_en_o,
   output      logic                     osc_colpitts_o,
   output      logic                     secured_o,
   output      logic                     debug_allowed_o,
   output      logic                     debug_active_o,
   output      logic                     debug_grant_o,
   output      logic                     debug_refuse_o,
   output      logic                     mode_wr_err_o,
   output      chip_cfg_pkg::pwr_state_t pwr_state_o,
   output      chip_cfg_pkg::clk_gate_t  clk_gate_o
);

   // Default flash visibility per mode and strap
   function automatic logic flash_default(
      input chip_cfg_pkg::op_mode_t m,
      input logic                   s
   );
      case (m)
         chip_cfg_pkg::MODE_SPECIAL_SINGLE: flash_default = 1'b1;
         chip_cfg_pkg::MODE_EMUL_NARROW:    flash_default = ~s;
         chip_cfg_pkg::MODE_SPECIAL_TEST:   flash_default = 1'b0;
         chip_cfg_pkg::MODE_EMUL_WIDE:      flash_default = ~s;
         chip_cfg_pkg::MODE_NORMAL_SINGLE:  flash_default = 1'b1;
         chip_cfg_pkg::MODE_NORMAL_NARROW:  flash_default = s;
         chip_cfg_pkg::MODE_PERIPHERAL:     flash_default = 1'b1;
         chip_cfg_pkg::MODE_NORMAL_WIDE:    flash_default = s;
         default:                           flash_default = 1'b1;
      endcase
   endfunction : flash_default

   // Special and emulation modes may go anywhere but peripheral; normal single chip may
   // only open its bus; every other running mode is locked
   function automatic logic mode_change_ok(
      input chip_cfg_pkg::op_mode_t cur,
      input chip_cfg_pkg::op_mode_t nxt
   );
      mode_change_ok = 1'b0;
      if (nxt != chip_cfg_pkg::MODE_PERIPHERAL)
      begin
         if (!cur[2])
         begin
            mode_change_ok = 1'b1;
         end
         else if (cur == chip_cfg_pkg::MODE_NORMAL_SINGLE)
         begin
            mode_change_ok = (nxt == chip_cfg_pkg::MODE_NORMAL_NARROW)
                          || (nxt == chip_cfg_pkg::MODE_NORMAL_WIDE);
         end
      end
   endfunction : mode_change_ok

   typedef struct packed {
      chip_cfg_pkg::cap_state_t cap;
      logic [2:0]               cnt;
      logic                     valid;
      chip_cfg_pkg::op_mode_t   mode;
      logic                     flash_vis;
      logic                     map_en;
      logic                     colpitts;
      logic                     secure;
      logic                     blank;
      logic                     dbg_allowed;
      logic                     dbg_active;
      logic                     dbg_grant;
      logic                     dbg_refuse;
      logic                     wr_err;
   } cfg_state_t;

   cfg_state_t             state_reg;
   cfg_state_t             state_next;
   chip_cfg_pkg::strap_t   strap_pins;
   chip_cfg_pkg::strap_t   strap_q;
   chip_cfg_pkg::op_mode_t strap_mode;
   logic                   dbg_blocked;

   // Strap pins share one synchroniser
   assign strap_pins = {mode_strap_high_i, mode_strap_mid_i,
                        mode_strap_low_i, flash_visible_strap_i,
                        oscillator_select_strap_i};

   strap_sync u_sync (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .pins_i   (strap_pins),
      .straps_o (strap_q)
   );

   assign strap_mode = chip_cfg_pkg::op_mode_t'({strap_q.mode_high,
                                                 strap_q.mode_mid,
                                                 strap_q.mode_low});

   // A blank-verified part in special single chip lets debug rewrite the
   // security bits; the security flag itself stays set until reset or the backdoor key
   assign dbg_blocked = state_reg.secure
      & ~(state_reg.blank
          & (state_reg.mode == chip_cfg_pkg::MODE_SPECIAL_SINGLE));

   // Capture after release, then run-time mode writes and debug gating
   always_comb
   begin
      state_next            = state_reg;
      state_next.dbg_grant  = 1'b0;
      state_next.dbg_refuse = 1'b0;
      state_next.wr_err     = 1'b0;
      case (state_reg.cap)
         chip_cfg_pkg::CAP_WAIT:
         begin
            state_next.cnt        = state_reg.cnt + 3'h1;
            state_next.dbg_refuse = debug_req_i;
            state_next.wr_err     = mode_wr_i;
            if (state_reg.cnt == chip_cfg_pkg::CAPTURE_CYCLES)
            begin
               state_next.cap       = chip_cfg_pkg::CAP_DONE;
               state_next.cnt       = state_reg.cnt;
               state_next.valid     = 1'b1;
               state_next.mode      = strap_mode;
               state_next.flash_vis = flash_default(strap_mode,
                                         strap_q.flash_vis);
               state_next.colpitts  = strap_q.osc_sel;
               // Security is re-read every reset
               state_next.secure    = secure_nv_i;
               state_next.blank     = flash_blank_i;
               state_next.dbg_active = (strap_mode
                  == chip_cfg_pkg::MODE_SPECIAL_SINGLE);
            end
         end
         chip_cfg_pkg::CAP_DONE:
         begin
            if (mode_wr_i)
            begin
               if (mode_change_ok(state_reg.mode, mode_wr_data_i))
               begin
                  state_next.mode = mode_wr_data_i;
               end
               else
               begin
                  state_next.wr_err = 1'b1;
               end
            end
            if (backdoor_key_ok_i)
            begin
               state_next.secure = 1'b0;
            end
            if (debug_activate_i && !dbg_blocked)
            begin
               state_next.dbg_active = 1'b1;
            end
            if (debug_req_i)
            begin
               if (state_reg.dbg_active && !dbg_blocked)
               begin
                  state_next.dbg_grant = 1'b1;
               end
               else
               begin
                  state_next.dbg_refuse = 1'b1;
               end
            end
         end
         default:
         begin
            state_next.cap = chip_cfg_pkg::CAP_WAIT;
         end
      endcase
      // Secured expanded parts run from external memory only
      state_next.map_en = state_next.valid & state_next.flash_vis
         & ~(state_next.secure
             & chip_cfg_pkg::is_expanded(state_next.mode));
      state_next.dbg_allowed = state_next.valid
         & ~(state_next.secure & ~(state_next.blank
             & (state_next.mode == chip_cfg_pkg::MODE_SPECIAL_SINGLE)));
   end

   // Constants only under reset; straps are caught later by capture
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state_reg      <= '0;
         state_reg.cap  <= chip_cfg_pkg::CAP_WAIT;
         state_reg.mode <= chip_cfg_pkg::MODE_SPECIAL_SINGLE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   power_modes u_pwr (
      .clk_i            (clk_i),
      .arst_n_i         (arst_n_i),
      .stop_exec_i      (stop_exec_i),
      .wait_exec_i      (wait_exec_i),
      .pseudo_stop_en_i (pseudo_stop_en_i),
      .tick_keep_i      (tick_keep_i),
      .wdog_keep_i      (wdog_keep_i),
      .ext_irq_i        (ext_irq_i),
      .tick_irq_i       (tick_irq_i),
      .any_irq_i        (any_irq_i),
      .pwr_state_o      (pwr_state_o),
      .gate_o           (clk_gate_o)
   );

   // Outputs straight from the state register
   assign config_valid_o      = state_reg.valid;
   assign op_mode_o           = state_reg.mode;
   assign flash_visible_bit_o = state_reg.flash_vis;
   assign flash_map_en_o      = state_reg.map_en;
   assign osc_colpitts_o      = state_reg.colpitts;
   assign secured_o           = state_reg.secure;
   assign debug_allowed_o     = state_reg.dbg_allowed;
   assign debug_active_o      = state_reg.dbg_active;
   assign debug_grant_o       = state_reg.dbg_grant;
   assign debug_refuse_o      = state_reg.dbg_refuse;
   assign mode_wr_err_o       = state_reg.wr_err;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   chk_mode_capture: assert property (
      $rose(config_valid_o) |-> op_mode_o == $past(strap_mode))
      else $error("mode not taken from straps");
   chk_special_start: assert property (
      $rose(config_valid_o)
      && op_mode_o == chip_cfg_pkg::MODE_SPECIAL_SINGLE
      |-> flash_visible_bit_o && debug_active_o)
      else $error("special single chip start wrong");
   chk_debug_idle: assert property (
      $rose(config_valid_o)
      && op_mode_o != chip_cfg_pkg::MODE_SPECIAL_SINGLE
      |-> !debug_active_o)
      else $error("debug active without command");
   chk_test_flash: assert property (
      $rose(config_valid_o)
      && op_mode_o == chip_cfg_pkg::MODE_SPECIAL_TEST
      |-> !flash_visible_bit_o)
      else $error("special test flash visible");
   chk_emul_flash: assert property (
      $rose(config_valid_o)
      && op_mode_o == chip_cfg_pkg::MODE_EMUL_NARROW
      |-> flash_visible_bit_o == !$past(strap_q.flash_vis))
      else $error("emulation narrow flash wrong");
   chk_narrow_flash: assert property (
      $rose(config_valid_o)
      && op_mode_o == chip_cfg_pkg::MODE_NORMAL_NARROW
      |-> flash_visible_bit_o == $past(strap_q.flash_vis))
      else $error("normal narrow flash wrong");
   chk_osc_pick: assert property (
      $rose(config_valid_o) |-> osc_colpitts_o == $past(strap_q.osc_sel))
      else $error("oscillator strap not taken");
   chk_wide_lock: assert property (
      config_valid_o && mode_wr_i
      && op_mode_o == chip_cfg_pkg::MODE_NORMAL_WIDE
      |=> $stable(op_mode_o) && mode_wr_err_o)
      else $error("locked mode was changed");
   chk_secure_refuse: assert property (
      config_valid_o && debug_req_i && secured_o
      && op_mode_o == chip_cfg_pkg::MODE_NORMAL_SINGLE
      |=> debug_refuse_o && !debug_grant_o)
      else $error("secured debug not refused");
   chk_secure_hide: assert property (
      secured_o && chip_cfg_pkg::is_expanded(op_mode_o)
      |-> !flash_map_en_o)
      else $error("secured expanded flash mapped");
   chk_secure_reload: assert property (
      $rose(config_valid_o) |-> secured_o == $past(secure_nv_i))
      else $error("security not reloaded");

   // Unsecured parts map flash exactly as the captured bit says; only a
   // blank part in special single chip or the key may open a secured one
   chk_flash_map: assert property (
      config_valid_o && !secured_o
      |-> flash_map_en_o == flash_visible_bit_o)
      else $error("flash map does not follow visibility");
   chk_key_clear: assert property (
      config_valid_o && backdoor_key_ok_i |=> !secured_o)
      else $error("backdoor key did not clear security");
   chk_blank_grant: assert property (
      debug_req_i && debug_active_o && state_reg.blank
      && op_mode_o == chip_cfg_pkg::MODE_SPECIAL_SINGLE
      |=> debug_grant_o)
      else $error("blank part refused debug");

   cov_special: cover property (
      $rose(config_valid_o)
      && op_mode_o == chip_cfg_pkg::MODE_SPECIAL_SINGLE);
   cov_mode_write: cover property (
      config_valid_o && mode_wr_i ##1 !mode_wr_err_o);
   cov_grant: cover property (debug_grant_o);
   cov_backdoor: cover property (secured_o ##1 !secured_o);
   cov_blank_grant: cover property (secured_o && debug_grant_o);

endmodule : chip_mode_config

// file: dv/board_straps.sv
// Board strap model: places the chosen strap levels on the pins, peripheral as normal wide.
// Assumes the bench holds its choice steady around reset release.
`timescale 1ns/1ps
module board_straps (
   input  wire logic [2:0] mode_i,
   input  wire logic       flash_i,
   input  wire logic       osc_i,
   output      logic [2:0] mode_o,
   output      logic       flash_o,
   output      logic       osc_o
);
   // The peripheral strap is never placed; bus conflicts on real boards
   assign mode_o  = (mode_i == 3'h6) ? 3'h7 : mode_i;
   assign flash_o = flash_i;
   assign osc_o   = osc_i;
endmodule : board_straps

// file: dv/testbench.sv
// Self-checking bench for chip_mode_config: straps, security, power.
// Assumes board_straps on the pins; inputs change on the falling edge.
`timescale 1ns/1ps
module testbench;
   logic       clk_i;
   logic       arst_n_i = 1'b0;
   logic [5:0] pl = 6'h00; // Pulses: wr, act, req, stop, wait, key
   logic [2:0] mv = 3'h4, wd = 3'h0, pin, sk;
   logic       fv = 1'b0, osc = 1'b0, sec = 1'b0, pse = 1'b0;
   logic       tk = 1'b0, ei = 1'b0, ti = 1'b0, ai = 1'b0, fb = 1'b0;
   logic       pfv, posc, cv, vis, map, col, secd, dac, gr, rf, we, da;
   chip_cfg_pkg::op_mode_t   om;
   chip_cfg_pkg::pwr_state_t ps;
   chip_cfg_pkg::clk_gate_t  cg;
   int         n_errors = 0, checks = 0, k;
   logic [2:0] m;
   logic       e;

   board_straps brd (.mode_i(mv), .flash_i(fv), .osc_i(osc),
      .mode_o(pin), .flash_o(pfv), .osc_o(posc));

   chip_mode_config dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .mode_strap_high_i(pin[2]), .mode_strap_mid_i(pin[1]),
      .mode_strap_low_i(pin[0]), .flash_visible_strap_i(pfv),
      .oscillator_select_strap_i(posc), .secure_nv_i(sec),
      .flash_blank_i(fb), .backdoor_key_ok_i(pl[0]),
      .mode_wr_i(pl[5]), .mode_wr_data_i(chip_cfg_pkg::op_mode_t'(wd)),
      .debug_activate_i(pl[4]), .debug_req_i(pl[3]),
      .stop_exec_i(pl[2]), .wait_exec_i(pl[1]),
      .pseudo_stop_en_i(pse), .tick_keep_i(tk), .wdog_keep_i(!tk),
      .ext_irq_i(ei), .tick_irq_i(ti), .any_irq_i(ai),
      .config_valid_o(cv), .op_mode_o(om), .flash_visible_bit_o(vis),
      .flash_map_en_o(map), .osc_colpitts_o(col), .secured_o(secd),
      .debug_allowed_o(da), .debug_active_o(dac), .debug_grant_o(gr),
      .debug_refuse_o(rf), .mode_wr_err_o(we), .pwr_state_o(ps),
      .clk_gate_o(cg));

   // 20 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   task complete_run();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : complete_run

   task chk(string nm, logic [7:0] s, logic [7:0] x);
      checks++;
      if (s !== x)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, x, s);
      end
   endtask : chk

   // Reset with new straps, then wait for capture under a bound
   task boot(logic [2:0] bm, logic bf, logic bs);
      @(negedge clk_i);
      {mv, fv, osc, sec} = {bm, bf, bf ^ bm[0], bs};
      arst_n_i = 1'b0;
      repeat (6) @(negedge clk_i);
      arst_n_i = 1'b1;
      for (int i = 0; i < 20 && cv !== 1'b1; i++) @(negedge clk_i);
      if (cv !== 1'b1)
      begin
         n_errors++;
         complete_run();
      end
   endtask : boot

   // Drop pulses after one cycle and collect answer pulses meanwhile
   task watch(int n);
      sk = 3'h0;
      repeat (n)
      begin
         @(negedge clk_i);
         // Clear at every edge, so no pulse lasts past the first cycle
         if (pl != 6'h00)
            pl = 6'h00;
         sk = sk | {gr, rf, we};
      end
   endtask : watch

   task t_capture();
      for (k = 0; k < 16; k++)
      begin
         m = k[3:1];
         if (m == 3'h6)
            continue;
         boot(m, k[0], 1'b0);
         e = (m == 3'h0 || m == 3'h4) ? 1'b1 :
             (m == 3'h2) ? 1'b0 : ~(m[2] ^ k[0]);
         chk("mode", om, m);
         chk("vis", vis, e);
         chk("vis", vis, e);
         chk("map", map, e);
         chk("osc", col, osc);
         chk("active", dac, m == 3'h0);
      end
   endtask : t_capture

   task t_debug();
      boot(3'h4, 1'b0, 1'b0);
      pl = 6'h08;
      watch(3);
      chk("req idle", {sk, da}, 4'h5);
      pl = 6'h10;
      watch(2);
      pl = 6'h08;
      watch(3);
      chk("req act", sk, 3'h4);
      boot(3'h4, 1'b0, 1'b1);
      pl = 6'h10;
      watch(2);
      pl = 6'h08;
      watch(3);
      chk("sec single", {sk, map, da}, 5'h0A);
      boot(3'h7, 1'b1, 1'b1);
      pl = 6'h08;
      watch(3);
      chk("sec wide", {sk, map, da}, 5'h08);
      pl = 6'h01;
      watch(2);
      chk("key", secd, 1'b0);
      boot(3'h7, 1'b1, 1'b1);
      chk("resecure", {secd, map}, 2'h2);
      // Blank secured part in special single chip: debug opens, still secured
      fb = 1'b1;
      boot(3'h0, 1'b0, 1'b1);
      pl = 6'h08;
      watch(3);
      chk("blank", {sk, secd, da}, 5'h13);
      fb = 1'b0;
   endtask : t_debug

   task t_write();
      boot(3'h4, 1'b0, 1'b0);
      for (k = 0; k < 3; k++)
      begin
         wd = (k == 1) ? 3'h5 : (k == 0) ? 3'h6 : 3'h0;
         pl = 6'h20;
         watch(3);
         chk("write", {sk[0], om}, k ? 4'h5 | k[1] << 3 : 4'hC);
      end
      // Special mode may open the wide bus, which then locks
      boot(3'h0, 1'b0, 1'b0);
      wd = 3'h7;
      pl = 6'h20;
      watch(3);
      chk("special wr", {sk[0], om}, 4'h7);
      wd = 3'h3;
      pl = 6'h20;
      watch(3);
      chk("wide lock", {sk[0], om}, 4'hF);
   endtask : t_write

   task t_power();
      boot(3'h4, 1'b0, 1'b0);
      pl = 6'h04;
      watch(2);
      ai = 1'b1;
      watch(2);
      chk("stop", {ps, cg}, 8'h81);
      {ai, ei} = 2'h1;
      watch(2);
      chk("wake", ps, 2'h0);
      {ei, pse, tk} = 3'h3;
      pl = 6'h04;
      watch(2);
      chk("pstop", {ps, cg}, 8'hE5);
      ti = 1'b1;
      watch(2);
      ti = 1'b0;
      pl = 6'h02;
      watch(2);
      chk("wait", {ps, cg}, 8'h6F);
      ai = 1'b1;
      watch(2);
      chk("resume", ps, 2'h0);
   endtask : t_power

   initial
   begin
      t_capture();
      t_debug();
      t_write();
      t_power();
      complete_run();
   end
endmodule : testbench
